// File: rrm_pkg.sv
package rrm_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  // base average refresh interval, longest time: round down
  localparam int REFI_BASE_NS  = 7800;
  localparam int REFI_BASE_CYC = REFI_BASE_NS / CLK_PERIOD_NS;
  // refresh cycle times, least times: round up
  localparam int RFC1_NS  = 260;
  localparam int RFC2_NS  = 160;
  localparam int RFC4_NS  = 110;
  localparam int RFC1_CYC = (RFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RFC2_CYC = (RFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RFC4_CYC = (RFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // settle gap after each mode register write
  localparam int MRS_GAP_NS  = 96;
  localparam int MRS_GAP_CYC = (MRS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W       = 12;
  localparam int ADDR_W      = 14;

  // ----------------------------------------------------------------
  // mode register layout
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_RATE_REG = 3'h3;  // {bg0,ba} of rate-mode register
  localparam logic [2:0] SEL_TEMP_REG = 3'h4;  // {bg0,ba} of temp-refresh register
  localparam int MODE_LSB    = 6;
  localparam int MODE_MSB    = 8;
  localparam int TCR_EN_BIT  = 3;
  localparam int TCR_EXT_BIT = 2;

  localparam logic [2:0] MODE_FIX1  = 3'h0;
  localparam logic [2:0] MODE_FIX2  = 3'h1;
  localparam logic [2:0] MODE_FIX4  = 3'h2;
  localparam logic [2:0] MODE_OTF12 = 3'h5;
  localparam logic [2:0] MODE_OTF14 = 3'h6;

  // ----------------------------------------------------------------
  // case temperature thresholds, degrees C, signed
  // ----------------------------------------------------------------
  localparam logic [7:0] TEMP_COOL_C = 8'h2d;  // 45
  localparam logic [7:0] TEMP_NORM_C = 8'h55;  // 85
  localparam logic [7:0] TEMP_HOT1_C = 8'h5f;  // 95
  localparam logic [7:0] TEMP_HOT2_C = 8'h69;  // 105

  typedef enum logic [1:0] {RRM_K1X, RRM_K2X, RRM_K4X} rrm_kind_t;

  // refresh type from mode and the bg0 pick
  function automatic rrm_kind_t rrm_kind_of(input logic [2:0] mode, input logic hi);
    rrm_kind_t k;
    k = RRM_K1X;
    if (mode == MODE_FIX2) begin
      k = RRM_K2X;
    end else if (mode == MODE_FIX4) begin
      k = RRM_K4X;
    end else if (mode == MODE_OTF12 && hi) begin
      k = RRM_K2X;
    end else if (mode == MODE_OTF14 && hi) begin
      k = RRM_K4X;
    end
    return k;
  endfunction

  // interval divisor exponent of a refresh type
  function automatic logic [2:0] rrm_kind_sh(input rrm_kind_t k);
    return (k == RRM_K4X) ? 3'h2 : (k == RRM_K2X) ? 3'h1 : 3'h0;
  endfunction

  // interval divisor exponent from case temperature
  function automatic logic [2:0] rrm_temp_sh(input logic [7:0] t);
    logic [2:0] s;
    s = 3'h0;
    if ($signed(t) > $signed(TEMP_HOT2_C)) begin
      s = 3'h3;
    end else if ($signed(t) > $signed(TEMP_HOT1_C)) begin
      s = 3'h2;
    end else if ($signed(t) > $signed(TEMP_NORM_C)) begin
      s = 3'h1;
    end
    return s;
  endfunction

  // refresh cycle time of a refresh type
  function automatic logic [TMR_W-1:0] rrm_rfc_cyc(input rrm_kind_t k);
    logic [TMR_W-1:0] c;
    c = TMR_W'(RFC1_CYC);
    if (k == RRM_K2X) begin
      c = TMR_W'(RFC2_CYC);
    end else if (k == RRM_K4X) begin
      c = TMR_W'(RFC4_CYC);
    end
    return c;
  endfunction

endpackage

// File: rrm_cmd_if.sv
`timescale 1ns/1ns
// command pins from controller to memory device
interface rrm_cmd_if;
  logic                       cs_n;
  logic                       act_n;
  logic                       ras_n;
  logic                       cas_n;
  logic                       we_n;
  logic                       bg0;
  logic [1:0]                 ba;
  logic [rrm_pkg::ADDR_W-1:0] addr;

  modport ctrl (output cs_n, act_n, ras_n, cas_n, we_n, bg0, ba, addr);
  modport dev  (input  cs_n, act_n, ras_n, cas_n, we_n, bg0, ba, addr);
endinterface

// File: rrm_timer.sv
`timescale 1ns/1ns
// load-and-count-down timer, done while count is zero
module rrm_timer #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         srst,
  // load
  input  wire logic         load,
  input  wire logic [W-1:0] val,
  // status
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } rrm_tmr_t;

  rrm_tmr_t q;
  rrm_tmr_t d;

  // next count
  always_comb begin
    d = q;
    if (load) begin
      d.cnt = val;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = (q.cnt == '0);
endmodule

// File: rrm_dev.sv
`timescale 1ns/1ns
// memory-device end: mode decode, refresh typing, temperature skipping
module rrm_dev (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // command pins
  rrm_cmd_if.dev           cmd,
  // case temperature sensor, degrees C signed
  input  wire logic [7:0]  temp_c,
  // refresh activity
  output logic             ref_exec,
  output logic             ref_skip,
  output rrm_pkg::rrm_kind_t ref_kind,
  output logic             busy,
  // programmed state
  output logic [2:0]       rate_mode,
  output logic             tcr_en,
  output logic             tcr_ext
);
  import rrm_pkg::*;

  typedef struct packed {
    logic [7:0] t1;
    logic [7:0] t2;
    logic [2:0] mode;
    logic       temperature_controlled_refresh;
    logic       ext;
    logic [1:0] gear;
    logic       exec;
    logic       skip;
    rrm_kind_t  kind;
    logic       busy;
  } rrm_dev_st_t;

  rrm_dev_st_t      q;
  rrm_dev_st_t      d;
  logic             tmr_ld;
  logic [TMR_W-1:0] tmr_val;
  logic             tmr_done;

  // -------------------------------------------------------------
  // refresh cycle timer
  // -------------------------------------------------------------
  rrm_timer #(.W(TMR_W)) u_rfc (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (tmr_ld),
    .val     (tmr_val),
    .done    (tmr_done)
  );

  // -------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------
  always_comb begin
    logic       is_cmd;
    logic       cool;
    logic       warm;
    logic [1:0] mask;
    rrm_kind_t  k;
    d       = q;
    d.t1    = temp_c;
    d.t2    = q.t1;
    d.exec  = 1'b0;
    d.skip  = 1'b0;
    d.busy  = !tmr_done;
    tmr_ld  = 1'b0;
    tmr_val = '0;
    is_cmd  = !cmd.cs_n && cmd.act_n && !cmd.ras_n && !cmd.cas_n;
    cool    = $signed(q.t2) < $signed(TEMP_COOL_C);
    warm    = $signed(q.t2) > $signed(TEMP_NORM_C);
    mask = 2'h0;
    if (q.temperature_controlled_refresh) begin
      if (q.ext) begin
        mask = cool ? 2'h3 : (warm ? 2'h0 : 2'h1);
      end else begin
        mask = cool ? 2'h1 : 2'h0;
      end
    end
    k = rrm_kind_of(q.mode, cmd.bg0);
    if (is_cmd && cmd.we_n) begin
      d.gear = q.temperature_controlled_refresh ? q.gear + 2'h1 : 2'h0;
      if ((q.gear & mask) == 2'h0) begin
        d.exec  = 1'b1;
        d.kind  = k;
        d.busy  = 1'b1;
        tmr_ld  = 1'b1;
        tmr_val = rrm_rfc_cyc(k);
      end else begin
        d.skip = 1'b1;
      end
    end else if (is_cmd && !cmd.we_n) begin
      if ({cmd.bg0, cmd.ba} == SEL_RATE_REG) begin
        d.mode = cmd.addr[MODE_MSB:MODE_LSB];
      end
      if ({cmd.bg0, cmd.ba} == SEL_TEMP_REG) begin
        d.temperature_controlled_refresh  = cmd.addr[TCR_EN_BIT];
        d.ext  = cmd.addr[TCR_EXT_BIT];
        d.gear = 2'h0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '{mode: MODE_FIX1, kind: RRM_K1X, default: '0};
    end else begin
      q <= d;
    end
  end

  // kind follows fixed or picked set
  assign ref_exec  = q.exec;
  assign ref_skip  = q.skip;
  assign ref_kind  = q.kind;
  assign busy      = q.busy;
  assign rate_mode = q.mode;
  assign tcr_en    = q.temperature_controlled_refresh;
  assign tcr_ext   = q.ext;
endmodule

// File: rrm_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - disabled: one refresh per average interval
// - device ignores range bit when disabled
// - enabled: device accepts all, skips by gear
// - range bit 0 normal, 1 extended
// - normal range: interval at most base
// - below 45C device may skip more
// - extended: faster refresh, device skips to base
// - extended range interval never above 3.9us
// - rate mode codes decode, three reserved
// - fixed single set, on-the-fly picks two
// - program on-the-fly mode before its refreshes
// - bg0 low single rate, high faster
// - double rate halves, quad quarters interval
// - default fixed single rate after reset
// - base 7.8us, divided further when hot
// - wait refresh cycle time of issued type
// - fixed mode issues only its own type
// - on-the-fly modes permit their two types
// - refresh is cs, ras, cas low, we high
// - postponement limited to 8, 16, 32
// - temperature refresh only in fixed single
module rrm_ctrl (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // command pins
  rrm_cmd_if.ctrl            cmd,
  // configuration request
  input  wire logic          cfg_apply,
  input  wire logic [2:0]    cfg_mode,
  input  wire logic          cfg_tcr,
  input  wire logic          cfg_ext,
  input  wire logic          hi_rate,
  // case temperature sensor, degrees C signed
  input  wire logic [7:0]    temp_c,
  // status
  output logic               ready,
  output logic               cfg_err,
  output logic               ref_issued,
  output rrm_pkg::rrm_kind_t ref_kind,
  output logic [2:0]         rate_mode,
  output logic               tcr_en,
  output logic               tcr_ext
);
  import rrm_pkg::*;

  typedef enum logic [2:0] {
    ST_OFF, ST_W_OFF, ST_RATE, ST_W_RATE, ST_TEMP, ST_W_TEMP, ST_RUN, ST_RFC
  } rrm_st_t;

  typedef struct packed {
    rrm_st_t           st;
    logic              cs_n;
    logic              act_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              bg0;
    logic [1:0]        ba;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        mode;
    logic              temperature_controlled_refresh;
    logic              ext;
    logic              pend;
    logic [2:0]        p_mode;
    logic              p_tcr;
    logic              p_ext;
    logic              err;
    logic [7:0]        t1;
    logic [7:0]        t2;
    logic              issued;
    rrm_kind_t         kind;
    logic              ready;
  } rrm_ctrl_st_t;

  rrm_ctrl_st_t     q;
  rrm_ctrl_st_t     d;
  logic             g_ld;
  logic [TMR_W-1:0] g_val;
  logic             g_done;
  logic             i_ld;
  logic [TMR_W-1:0] i_val;
  logic             i_done;

  // -------------------------------------------------------------
  // gap and interval timers
  // -------------------------------------------------------------
  rrm_timer #(.W(TMR_W)) u_gap (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (g_ld),
    .val     (g_val),
    .done    (g_done)
  );

  rrm_timer #(.W(TMR_W)) u_ivl (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (i_ld),
    .val     (i_val),
    .done    (i_done)
  );

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  always_comb begin
    rrm_kind_t  k;
    logic [2:0] ts;
    logic [2:0] sh;
    d        = q;
    d.t1     = temp_c;
    d.t2     = q.t1;
    d.cs_n   = 1'b1;
    d.act_n  = 1'b1;
    d.ras_n  = 1'b1;
    d.cas_n  = 1'b1;
    d.we_n   = 1'b1;
    d.bg0    = 1'b0;
    d.ba     = 2'h0;
    d.addr   = '0;
    d.issued = 1'b0;
    g_ld     = 1'b0;
    g_val    = '0;
    i_ld     = 1'b0;
    i_val    = '0;
    k  = rrm_kind_of(q.mode, hi_rate);
    ts = rrm_temp_sh(q.t2);
    // extended range: at most half base
    if (q.temperature_controlled_refresh && q.ext && ts == 3'h0) begin
      ts = 3'h1;
    end
    sh = rrm_kind_sh(k) + ts;
    unique case (q.st)
      ST_OFF: begin
        {d.cs_n, d.ras_n, d.cas_n, d.we_n} = 4'h0;
        {d.bg0, d.ba}                      = SEL_TEMP_REG;
        g_ld                               = 1'b1;
        g_val                              = TMR_W'(MRS_GAP_CYC);
        d.st                               = ST_W_OFF;
      end
      ST_W_OFF: begin
        if (g_done) begin
          d.st = ST_RATE;
        end
      end
      ST_RATE: begin
        {d.cs_n, d.ras_n, d.cas_n, d.we_n} = 4'h0;
        {d.bg0, d.ba}                      = SEL_RATE_REG;
        d.addr[MODE_MSB:MODE_LSB]          = q.mode;
        g_ld                               = 1'b1;
        g_val                              = TMR_W'(MRS_GAP_CYC);
        d.st                               = ST_W_RATE;
      end
      ST_W_RATE: begin
        if (g_done) begin
          d.st = ST_TEMP;
        end
      end
      ST_TEMP: begin
        {d.cs_n, d.ras_n, d.cas_n, d.we_n} = 4'h0;
        {d.bg0, d.ba}                      = SEL_TEMP_REG;
        d.addr[TCR_EN_BIT]                 = q.temperature_controlled_refresh;
        d.addr[TCR_EXT_BIT]                = q.ext;
        g_ld                               = 1'b1;
        g_val                              = TMR_W'(MRS_GAP_CYC);
        d.st                               = ST_W_TEMP;
      end
      ST_W_TEMP: begin
        if (g_done) begin
          d.ready = 1'b1;
          d.st    = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_done) begin
          {d.cs_n, d.ras_n, d.cas_n} = 3'h0;
          d.bg0    = hi_rate && q.mode[2];
          d.issued = 1'b1;
          d.kind   = k;
          i_ld     = 1'b1;
          i_val    = TMR_W'((REFI_BASE_CYC >> sh) - 1);  // zero counts as a cycle
          // hold off for the cycle time
          g_ld     = 1'b1;
          g_val    = rrm_rfc_cyc(k);
          d.st     = ST_RFC;
        end else if (q.pend) begin
          d.mode  = q.p_mode;
          d.temperature_controlled_refresh   = q.p_tcr;
          d.ext   = q.p_ext;
          d.pend  = 1'b0;
          d.ready = 1'b0;
          d.st    = ST_OFF;
        end
      end
      ST_RFC: begin
        if (g_done) begin
          d.st = ST_RUN;
        end
      end
    endcase
    if (cfg_apply) begin
      if (cfg_mode == 3'h3 || cfg_mode == 3'h4 || cfg_mode == 3'h7) begin
        d.err = 1'b1;
      end else begin
        d.err    = 1'b0;
        d.pend   = 1'b1;
        d.p_mode = cfg_mode;
        // enable only with fixed single rate
        d.p_tcr  = cfg_tcr && cfg_mode == MODE_FIX1;
        d.p_ext  = cfg_ext;
      end
    end
  end

  // reset to fixed single rate, pins idle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '{st: ST_OFF, cs_n: 1'b1, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
             we_n: 1'b1, mode: MODE_FIX1, p_mode: MODE_FIX1, kind: RRM_K1X,
             default: '0};
    end else begin
      q <= d;
    end
  end

  // outputs from state
  assign cmd.cs_n   = q.cs_n;
  assign cmd.act_n  = q.act_n;
  assign cmd.ras_n  = q.ras_n;
  assign cmd.cas_n  = q.cas_n;
  assign cmd.we_n   = q.we_n;
  assign cmd.bg0    = q.bg0;
  assign cmd.ba     = q.ba;
  assign cmd.addr   = q.addr;
  assign ready      = q.ready;
  assign cfg_err    = q.err;
  assign ref_issued = q.issued;
  assign ref_kind   = q.kind;
  assign rate_mode  = q.mode;
  assign tcr_en     = q.temperature_controlled_refresh;
  assign tcr_ext    = q.ext;
endmodule

// File: rrm_refresh_asserts.sv
`timescale 1ns/1ns
module rrm_refresh_asserts
  import rrm_pkg::*;
(
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       srst,
  // command pins
  input wire logic                       cs_n,
  input wire logic                       act_n,
  input wire logic                       ras_n,
  input wire logic                       cas_n,
  input wire logic                       we_n,
  input wire logic                       bg0,
  input wire logic [1:0]                 ba,
  input wire logic [rrm_pkg::ADDR_W-1:0] addr,
  // device status
  input wire logic                       ref_exec,
  input wire logic                       ref_skip,
  input wire rrm_pkg::rrm_kind_t         ref_kind,
  input wire logic                       busy,
  input wire logic [2:0]                 rate_mode,
  input wire logic                       tcr_en,
  input wire logic                       tcr_ext
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic             is_ref;
  logic             is_mrs;
  logic [2:0]       mode_fld;
  logic [1:0]       tcr_fld;
  rrm_kind_t        kind_c;
  rrm_kind_t        kind_q;
  logic [TMR_W-1:0] since_q;
  logic [TMR_W-1:0] rfc_q;

  default clocking dclk @(posedge ref_clk); endclocking
  default disable iff (srst);

  // command decode and kind of a refresh on the pins
  always_comb begin
    is_ref = !cs_n && act_n && !ras_n && !cas_n && we_n;
    is_mrs = !cs_n && act_n && !ras_n && !cas_n && !we_n;
    mode_fld = addr[MODE_MSB:MODE_LSB];
    tcr_fld = {addr[TCR_EN_BIT], addr[TCR_EXT_BIT]};
    kind_c = RRM_K1X;
    if (rate_mode == MODE_FIX2 || (rate_mode == MODE_OTF12 && bg0)) kind_c = RRM_K2X;
    else if (rate_mode == MODE_FIX4 || (rate_mode == MODE_OTF14 && bg0)) kind_c = RRM_K4X;
  end

  // cycles since last refresh and its cycle time
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      since_q <= '1;
      rfc_q <= '0;
      kind_q <= RRM_K1X;
    end else if (is_ref) begin
      since_q <= TMR_W'(1);
      rfc_q <= (kind_c == RRM_K4X) ? TMR_W'(RFC4_CYC) :
               (kind_c == RRM_K2X) ? TMR_W'(RFC2_CYC) : TMR_W'(RFC1_CYC);
      kind_q <= kind_c;
    end else if (since_q != '1) begin
      since_q <= since_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_REF_ANSWER: assert property (is_ref |=> ref_exec ^ ref_skip)
    else $error("refresh command got no single device answer");
  AST_EXEC_SRC: assert property (ref_exec |-> $past(is_ref))
    else $error("device executed without a refresh command");
  AST_REF_KIND: assert property (ref_exec |-> ref_kind == kind_q)
    else $error("executed refresh kind differs from mode and bg0");
  AST_RFC_GAP: assert property (is_ref |-> since_q >= rfc_q)
    else $error("refresh closer than refresh cycle time");
  AST_BUSY_HOLD: assert property (ref_exec |-> busy [*8])
    else $error("busy not held after executed refresh");
  AST_FIX_BG0: assert property (is_ref && !rate_mode[2] |-> !bg0)
    else $error("fixed mode refresh with bg0 high");
  AST_RATE_DECODE: assert property (is_mrs && {bg0, ba} == SEL_RATE_REG
      |=> rate_mode == $past(mode_fld))
    else $error("rate mode not decoded from write");
  AST_TEMP_DECODE: assert property (is_mrs && {bg0, ba} == SEL_TEMP_REG
      |=> {tcr_en, tcr_ext} == $past(tcr_fld))
    else $error("temperature refresh bits not decoded from write");
  AST_TCR_FIX1: assert property (tcr_en |-> rate_mode == MODE_FIX1)
    else $error("temperature refresh on outside fixed single rate");
  AST_TCR_OFF_ALL: assert property (is_ref && !tcr_en |=> ref_exec)
    else $error("refresh skipped with temperature refresh off");
endmodule

// File: test_refresh_rate_mode_control.sv
`timescale 1ns/1ns
module test_refresh_rate_mode_control;
  import rrm_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic       ref_clk, srst, cfg_apply, cfg_tcr, cfg_ext, hi_rate;
  logic [2:0] cfg_mode, c_mode, d_mode;
  logic [7:0] temp_c;
  logic       ready, cfg_err, ref_issued, c_tcr, c_ext;
  logic       ref_exec, ref_skip, busy, d_tcr, d_ext;
  rrm_kind_t  c_kind, d_kind;
  int         failures, n_compared;
  int         cycles = 0;
  int         n_iss  = 0;
  int         n_ans  = 0;
  rrm_cmd_if  cmd_bus ();

  rrm_ctrl rrm_ctrl_inst (.ref_clk(ref_clk), .srst(srst), .cmd(cmd_bus),
    .cfg_apply(cfg_apply), .cfg_mode(cfg_mode), .cfg_tcr(cfg_tcr), .cfg_ext(cfg_ext),
    .hi_rate(hi_rate), .temp_c(temp_c), .ready(ready), .cfg_err(cfg_err),
    .ref_issued(ref_issued), .ref_kind(c_kind), .rate_mode(c_mode), .tcr_en(c_tcr),
    .tcr_ext(c_ext));
  rrm_dev rrm_dev_inst (.ref_clk(ref_clk), .srst(srst), .cmd(cmd_bus), .temp_c(temp_c),
    .ref_exec(ref_exec), .ref_skip(ref_skip), .ref_kind(d_kind), .busy(busy),
    .rate_mode(d_mode), .tcr_en(d_tcr), .tcr_ext(d_ext));
  rrm_refresh_asserts rrm_refresh_asserts_inst (.ref_clk(ref_clk), .srst(srst),
    .cs_n(cmd_bus.cs_n), .act_n(cmd_bus.act_n), .ras_n(cmd_bus.ras_n),
    .cas_n(cmd_bus.cas_n), .we_n(cmd_bus.we_n), .bg0(cmd_bus.bg0), .ba(cmd_bus.ba),
    .addr(cmd_bus.addr), .ref_exec(ref_exec), .ref_skip(ref_skip), .ref_kind(d_kind),
    .busy(busy), .rate_mode(d_mode), .tcr_en(d_tcr), .tcr_ext(d_ext));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_gap(input int g, input int sh);
    chk(32'(g <= (REFI_BASE_CYC >> sh) && g + 2 >= (REFI_BASE_CYC >> sh)), 32'h1);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready === 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (ready !== 1'b1 && n < 3300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(32'(n < 3300), 32'h1);
  endtask

  // next refresh answer; g is the gap to the previous one
  task automatic wait_ref(output int g, output logic e, output rrm_kind_t k);
    g = 0;
    do begin
      @(posedge ref_clk);
      #1;
      g++;
    end while (!(ref_exec === 1'b1 || ref_skip === 1'b1) && g < 4000);
    e = ref_exec;
    k = d_kind;
    chk(32'(g < 4000), 32'h1);
  endtask

  task automatic apply(input logic [2:0] m, input logic t, input logic x, input logic bad);
    @(posedge ref_clk);
    cfg_apply <= 1'b1;
    cfg_mode <= m;
    cfg_tcr <= t;
    cfg_ext <= x;
    @(posedge ref_clk);
    cfg_apply <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(32'(cfg_err), 32'(bad));
    if (!bad) wait_ready();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    int g;
    logic e;
    rrm_kind_t k;
    #1;
    chk(32'(d_mode), 32'h0);
    @(posedge ref_clk);
    srst <= 1'b0;
    wait_ready();
    repeat (2) wait_ref(g, e, k);
    chk(32'(k), 32'(RRM_K1X));
    chk_gap(g, 0);
    @(posedge ref_clk);
    #1;
    chk(32'(n_iss), 32'(n_ans));
  endtask

  task automatic t_modes();
    logic [2:0] m;
    int g, kx;
    logic e;
    rrm_kind_t k;
    for (int i = 0; i < 5; i++) begin
      m = (i < 3) ? 3'(i) : 3'(i + 2);
      apply(m, 1'b0, 1'b0, 1'b0);
      chk(32'(d_mode), 32'(m));
      for (int h = (m[2] ? 0 : 1); h < 2; h++) begin
        @(posedge ref_clk);
        hi_rate <= h[0];
        repeat (3) wait_ref(g, e, k);
        kx = (m == 3'h0 || (m[2] && h == 0)) ? 0 : (m[0] ? 1 : 2);
        chk(32'(k), 32'(kx));
        chk(32'(c_kind), 32'(kx));
        chk_gap(g, kx);
      end
    end
  endtask

  task automatic t_reserved();
    for (int i = 0; i < 3; i++) begin
      apply((i == 2) ? 3'h7 : 3'(i + 3), 1'b0, 1'b0, 1'b1);
      chk(32'(c_mode), 32'h6);
      chk(32'(d_mode), 32'h6);
    end
    apply(3'h0, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_heat();
    int g;
    logic e;
    rrm_kind_t k;
    for (int s = 1; s <= 3; s++) begin
      @(posedge ref_clk);
      temp_c <= 8'(80 + 10 * s);
      repeat (3) wait_ref(g, e, k);
      chk_gap(g, s);
    end
  endtask

  task automatic t_tcr();
    int g, cnt;
    logic e;
    rrm_kind_t k;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      temp_c <= (i == 0) ? 8'h3c : 8'h1e;
      apply(3'h0, 1'(i != 3), 1'(i != 2), 1'b0);
      chk(32'(d_tcr), 32'(i != 3));
      chk(32'(c_tcr), 32'(i != 3));
      chk(32'(c_ext), 32'(i != 2));
      wait_ref(g, e, k);
      cnt = 0;
      repeat (4) begin
        wait_ref(g, e, k);
        cnt = cnt + ((e === 1'b1) ? 1 : 0);
      end
      chk(32'(cnt), (i == 3) ? 32'h4 : (i == 1) ? 32'h1 : 32'h2);
      chk_gap(g, (i < 2) ? 1 : 0);
    end
    apply(3'h1, 1'b1, 1'b0, 1'b0);
    chk(32'(d_tcr), 32'h0);
    chk(32'(n_iss), 32'(n_ans));
  endtask

  // ---------------------------------------------------------------
  // closing report
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // clock generation
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures++;
      end_sim();
    end
  end

  // refresh commands issued and device answers seen
  always @(posedge ref_clk) begin
    if (ref_issued === 1'b1) n_iss <= n_iss + 1;
    if (ref_exec === 1'b1 || ref_skip === 1'b1) n_ans <= n_ans + 1;
  end

  // main sequence
  initial begin
    srst = 1'b1;
    cfg_apply = 1'b0;
    cfg_mode = 3'h0;
    cfg_tcr = 1'b0;
    cfg_ext = 1'b0;
    hi_rate = 1'b0;
    temp_c = 8'h19;
    failures = 0;
    n_compared = 0;
    repeat (16) @(posedge ref_clk);
    t_reset();
    t_modes();
    t_reserved();
    t_heat();
    t_tcr();
    end_sim();
  end
endmodule
